// ===== rtl/otp_lock_pkg.sv
package otp_lock_pkg;
  // Channel count and code width
  localparam int CHANNELS = 20;
  localparam int CODE_W = 10;
  // Register addresses
  localparam logic [4:0] LAST_DAC_ADDR = 5'h13;
  localparam logic [4:0] LOCK_ADDR = 5'h14;
  // Lock bit position in the lock register
  localparam int LOCK_BIT = 0;
  // Field pattern in bits 15:14 that selects OTP programming
  localparam logic [1:0] OTP_SEL = 2'h1;
  // Output code used when an OTP location is blank
  localparam logic [9:0] MIDSCALE = 10'h200;
  // Reset values
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Bits in one serial byte, index of the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Arbitrary neutral bus address of this part
  localparam logic [6:0] DEV_ADDR = 7'h4a;

  // One 16-bit register word as received from the link
  typedef struct packed {
    logic load;             // Bit 15: load all channels
    logic sel;              // Bit 14: with bit 15 forms OTP select
    logic [3:0] unused;     // Bits 13:10
    logic [9:0] code;       // Bits 9:0: DAC code
  } dac_word_t;

  // A finished register write handed to the register bank
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    dac_word_t word;
  } reg_write_t;

  // Serial engine states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_PTR   = 3'b011,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b110
  } link_state_t;
endpackage

// ===== rtl/dac_channel.sv
// One channel: input register, OTP copy and output latch
module dac_channel #(
  parameter int CODE_W = 10
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic init_i,
  input wire logic [CODE_W-1:0] init_code_i,
  input wire logic init_used_i,
  input wire logic wr_i,
  input wire logic pgm_i,
  input wire logic [CODE_W-1:0] code_i,
  input wire logic load_i,
  output logic [CODE_W-1:0] in_code_o,
  output logic [CODE_W-1:0] otp_code_o,
  output logic [CODE_W-1:0] dac_code_o
);
  logic [CODE_W-1:0] in_ff;   // First register bank
  logic [CODE_W-1:0] otp_ff;  // Working copy of the fuse cells
  logic [CODE_W-1:0] dac_ff;  // Code seen by the analog output
  logic [CODE_W-1:0] nxt_otp; // Fuses can only gain ones
  logic [CODE_W-1:0] nxt_in;
  logic [CODE_W-1:0] boot_code;

  // Blank fuse locations come up at midscale
  always_comb begin
    boot_code = init_used_i ? init_code_i : otp_lock_pkg::MIDSCALE;
    nxt_otp = otp_ff | code_i;
    nxt_in = wr_i ? code_i : in_ff;
  end

  // Fuse copy is captured once after reset and then only ORed
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_ff <= otp_lock_pkg::CODE_RST;
    end else if (init_i) begin
      otp_ff <= init_code_i;
    end else if (pgm_i) begin
      otp_ff <= nxt_otp;
    end
  end

  // Input bank takes writes; programming also reloads it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_ff <= otp_lock_pkg::CODE_RST;
    end else if (init_i) begin
      in_ff <= boot_code;
    end else if (pgm_i) begin
      in_ff <= nxt_otp;
    end else begin
      in_ff <= nxt_in;
    end
  end

  // Output latch moves only on boot, programming or a load event
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_ff <= otp_lock_pkg::CODE_RST;
    end else if (init_i) begin
      dac_ff <= boot_code;
    end else if (pgm_i) begin
      dac_ff <= nxt_otp;
    end else if (load_i) begin
      dac_ff <= nxt_in;
    end
  end

  assign in_code_o = in_ff;
  assign otp_code_o = otp_ff;
  assign dac_code_o = dac_ff;

  AST_OTP_MONOTONIC: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !$past(init_i) |-> (($past(otp_ff) & ~otp_ff) == '0))
    else $error("OTP bit went from one to zero");
  AST_OUT_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !init_i && !pgm_i && !load_i |=> $stable(dac_ff))
    else $error("Output changed without a load event");
  AST_LOAD_ALL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    load_i && !init_i && !pgm_i |=> dac_ff == in_ff)
    else $error("Load event did not copy the input bank");
  AST_PGM_UPDATES: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pgm_i && !init_i |=> dac_ff == otp_ff && in_ff == otp_ff)
    else $error("Programming did not update register and output");
  AST_BOOT_VALUE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rst_n_i && init_i |=> dac_ff == (init_used_i ? init_code_i : otp_lock_pkg::MIDSCALE))
    else $error("Output did not come up at fuse value or midscale");
endmodule

// ===== rtl/otp_lock_and_dac_load.sv
module otp_lock_and_dac_load #(
  parameter logic [6:0] DEV_ADDR = otp_lock_pkg::DEV_ADDR
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic output_load_strobe_n_i,
  input wire logic [otp_lock_pkg::CHANNELS-1:0][otp_lock_pkg::CODE_W-1:0] fuse_code_i,
  input wire logic [otp_lock_pkg::CHANNELS-1:0] fuse_used_i,
  output logic [otp_lock_pkg::CHANNELS-1:0][otp_lock_pkg::CODE_W-1:0] dac_code_o,
  output logic lock_o
);
  localparam int CH = otp_lock_pkg::CHANNELS;
  localparam int CW = otp_lock_pkg::CODE_W;

  logic rst_s1_ff, rst_n_ff;            // Reset release synchroniser
  logic scl_s1_ff, scl_s2_ff, scl_q_ff; // Link clock sampled by mclk
  logic sda_s1_ff, sda_s2_ff, sda_q_ff; // Link data sampled by mclk
  logic ld_s1_ff, ld_s2_ff;             // Load strobe pin, active low
  logic init_done_ff;                   // Fuse image captured
  logic lock_ff;                        // OTP write lock
  otp_lock_pkg::link_state_t state_ff;
  logic [3:0] cnt_ff;                   // Bits seen in the current byte
  logic ack_ff;                         // In the acknowledge slot
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [7:0] hi_ff;                    // High byte awaiting its partner
  logic have_hi_ff;
  logic rd_lo_ff;                       // Next read byte is the low one
  logic mnack_ff;                       // Master declined the last byte
  logic [4:0] ptr_ff;
  logic sda_oe_ff;
  otp_lock_pkg::reg_write_t cmt_ff;     // Completed write, one-cycle pulse
  logic [CH-1:0][CW-1:0] in_code, otp_code, dac_code;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] rx_full;
  logic [15:0] rd_word;
  logic otp_req, load_all, init_pulse;

  // Release reset through two flops; the rest uses the copy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // Pins come from outside the mclk domain: two flops, then a delay for edges
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      ld_s1_ff <= 1'b1;
      ld_s2_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_q_ff <= scl_s2_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_q_ff <= sda_s2_ff;
      ld_s1_ff <= output_load_strobe_n_i;
      ld_s2_ff <= ld_s1_ff;
    end
  end

  // Edge and bus-condition decode from second-stage copies and their delayed third-stage copies
  always_comb begin
    scl_rise = scl_s2_ff && !scl_q_ff;
    scl_fall = !scl_s2_ff && scl_q_ff;
    start_seen = scl_s2_ff && scl_q_ff && sda_q_ff && !sda_s2_ff;
    stop_seen = scl_s2_ff && scl_q_ff && !sda_q_ff && sda_s2_ff;
    rx_full = rx_ff;
    // Lock register reads its bit in D0, upper bits zero
    if (ptr_ff == otp_lock_pkg::LOCK_ADDR) begin
      rd_word = 16'h0000;
      rd_word[otp_lock_pkg::LOCK_BIT] = lock_ff;
    end else if (ptr_ff < otp_lock_pkg::LOCK_ADDR) begin
      rd_word = {6'h00, in_code[ptr_ff]};
    end else begin
      rd_word = otp_lock_pkg::WORD_RST;
    end
  end

  // Byte engine: shifts on rising scl, acts and drives on falling scl
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= otp_lock_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      hi_ff <= 8'h00;
      have_hi_ff <= 1'b0;
      rd_lo_ff <= 1'b0;
      mnack_ff <= 1'b0;
      ptr_ff <= 5'h00;
      sda_oe_ff <= 1'b0;
      cmt_ff <= '0;
    end else begin
      cmt_ff.valid <= 1'b0;
      if (start_seen) begin
        // A half-received word is dropped on a new start
        state_ff <= otp_lock_pkg::ST_ADDR;
        cnt_ff <= 4'h0;
        ack_ff <= 1'b0;
        have_hi_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (stop_seen) begin
        state_ff <= otp_lock_pkg::ST_IDLE;
        have_hi_ff <= 1'b0;
        sda_oe_ff <= 1'b0;
      end else if (state_ff == otp_lock_pkg::ST_IDLE) begin
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        if (!ack_ff && cnt_ff < otp_lock_pkg::ACK_SLOT) begin
          rx_ff <= {rx_ff[6:0], sda_s2_ff};
          cnt_ff <= cnt_ff + 4'h1;
        end else if (ack_ff) begin
          mnack_ff <= sda_s2_ff;
        end
      end else if (scl_fall) begin
        if (ack_ff) begin
          // End of acknowledge slot
          ack_ff <= 1'b0;
          cnt_ff <= 4'h0;
          if (state_ff == otp_lock_pkg::ST_READ) begin
            if (mnack_ff) begin
              state_ff <= otp_lock_pkg::ST_IDLE;
              sda_oe_ff <= 1'b0;
            end else begin
              tx_ff <= rd_lo_ff ? rd_word[7:0] : rd_word[15:8];
              sda_oe_ff <= rd_lo_ff ? !rd_word[7] : !rd_word[15];
            end
          end else begin
            sda_oe_ff <= 1'b0;
          end
        end else if (cnt_ff == otp_lock_pkg::ACK_SLOT) begin
          ack_ff <= 1'b1;
          mnack_ff <= 1'b0;
          sda_oe_ff <= 1'b1;
          unique case (state_ff)
            otp_lock_pkg::ST_ADDR: begin
              if (rx_full[7:1] != DEV_ADDR) begin
                // Not our address: no acknowledge slot follows
                state_ff <= otp_lock_pkg::ST_IDLE;
                ack_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
              end else if (rx_full[0]) begin
                state_ff <= otp_lock_pkg::ST_READ;
                rd_lo_ff <= 1'b0;
              end else begin
                state_ff <= otp_lock_pkg::ST_PTR;
              end
            end
            otp_lock_pkg::ST_PTR: begin
              if (rx_full[7:5] == 3'h0 && rx_full[4:0] <= otp_lock_pkg::LOCK_ADDR) begin
                ptr_ff <= rx_full[4:0];
                state_ff <= otp_lock_pkg::ST_WRITE;
                have_hi_ff <= 1'b0;
              end else begin
                state_ff <= otp_lock_pkg::ST_IDLE;
                ack_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
              end
            end
            otp_lock_pkg::ST_WRITE: begin
              if (!have_hi_ff) begin
                hi_ff <= rx_full;
                have_hi_ff <= 1'b1;
              end else begin
                // Word complete on its last bit: hand it to the bank
                cmt_ff.valid <= 1'b1;
                cmt_ff.addr <= ptr_ff;
                cmt_ff.word <= {hi_ff, rx_full};
                have_hi_ff <= 1'b0;
                // Auto-increment never reaches the lock register
                if (ptr_ff < otp_lock_pkg::LAST_DAC_ADDR) begin
                  ptr_ff <= ptr_ff + 5'h01;
                end
              end
            end
            otp_lock_pkg::ST_READ: begin
              sda_oe_ff <= 1'b0;
              rd_lo_ff <= !rd_lo_ff;
              if (rd_lo_ff && ptr_ff < otp_lock_pkg::LAST_DAC_ADDR) begin
                ptr_ff <= ptr_ff + 5'h01;
              end
            end
            default: begin
              state_ff <= otp_lock_pkg::ST_IDLE;
              ack_ff <= 1'b0;
              sda_oe_ff <= 1'b0;
            end
          endcase
        end else if (state_ff == otp_lock_pkg::ST_READ) begin
          // Shift out the next data bit, MSB first
          sda_oe_ff <= !tx_ff[3'(7 - cnt_ff)];
        end
      end
    end
  end

  // Lock is sticky: once set, only a reset clears it
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lock_ff <= 1'b0;
    end else if (cmt_ff.valid && cmt_ff.addr == otp_lock_pkg::LOCK_ADDR
                 && cmt_ff.word[otp_lock_pkg::LOCK_BIT]) begin
      lock_ff <= 1'b1;
    end
  end

  // Fuse image is taken one cycle after reset release, never under reset
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      init_done_ff <= 1'b0;
    end else begin
      init_done_ff <= 1'b1;
    end
  end

  // Sda output level is always low; only the enable moves (open drain)
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  always_comb begin
    init_pulse = !init_done_ff;
    otp_req = {cmt_ff.word.load, cmt_ff.word.sel} == otp_lock_pkg::OTP_SEL;
    // Pin held low or a normal write with bit 15 loads every channel
    load_all = !ld_s2_ff || (cmt_ff.valid && !otp_req && cmt_ff.word.load);
  end

  for (genvar i = 0; i < CH; i++) begin : g_ch
    dac_channel #(.CODE_W(CW)) u_ch (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_ff),
      .init_i(init_pulse),
      .init_code_i(fuse_code_i[i]),
      .init_used_i(fuse_used_i[i]),
      .wr_i(cmt_ff.valid && !otp_req && cmt_ff.addr == 5'(i)),
      .pgm_i(cmt_ff.valid && otp_req && !lock_ff && cmt_ff.addr == 5'(i)),
      .code_i(cmt_ff.word.code),
      .load_i(load_all),
      .in_code_o(in_code[i]),
      .otp_code_o(otp_code[i]),
      .dac_code_o(dac_code[i])
    );
  end

  assign dac_code_o = dac_code;
  assign lock_o = lock_ff;
  assign sda_oe_o = sda_oe_ff;

  AST_LOCK_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    lock_ff |=> lock_ff [*4])
    else $error("Lock bit cleared");
  AST_LOCK_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    cmt_ff.valid && cmt_ff.addr == otp_lock_pkg::LOCK_ADDR && cmt_ff.word[0] |=> lock_ff)
    else $error("Lock write did not set lock");
  AST_LOCK_READ: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    ptr_ff == otp_lock_pkg::LOCK_ADDR |-> rd_word == {15'h0000, lock_ff})
    else $error("Lock bit not on read path");
  AST_LOCKED_NO_PGM: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    lock_ff && cmt_ff.valid && otp_req |=> $stable(otp_code))
    else $error("OTP changed while locked");
  AST_NORMAL_NO_OTP: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    init_done_ff && cmt_ff.valid && !otp_req |=> $stable(otp_code))
    else $error("Normal write touched OTP");
  AST_BAD_PTR_NACK: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    state_ff == otp_lock_pkg::ST_PTR && scl_fall && !ack_ff && cnt_ff == 4'h8
    && !start_seen && !stop_seen && rx_ff[7:0] > 8'h14 |=> !sda_oe_ff && !ack_ff ##0
    state_ff == otp_lock_pkg::ST_IDLE)
    else $error("Out of range address acknowledged");
  AST_SW_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    init_done_ff && cmt_ff.valid && !otp_req && cmt_ff.word.load |=> dac_code == in_code)
    else $error("Bit-15 write did not load all channels");
  AST_PIN_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    init_done_ff && !ld_s2_ff && !cmt_ff.valid |=> dac_code == in_code)
    else $error("Load pin did not load all channels");

  COV_OTP_PGM: cover property (@(posedge mclk_i) disable iff (!rst_n_ff)
    cmt_ff.valid && otp_req && !lock_ff);
  COV_LOCK: cover property (@(posedge mclk_i) disable iff (!rst_n_ff)
    $rose(lock_ff));
  COV_SW_LOAD: cover property (@(posedge mclk_i) disable iff (!rst_n_ff)
    cmt_ff.valid && !otp_req && cmt_ff.word.load);
  COV_READ: cover property (@(posedge mclk_i) disable iff (!rst_n_ff)
    state_ff == otp_lock_pkg::ST_READ && rd_lo_ff);
endmodule

// ===== verification/twowire_host.sv
// Behavioural two-wire bus master; scl stands high between frames
module twowire_host #(
  parameter logic [6:0] DEV_ADDR = otp_lock_pkg::DEV_ADDR
) (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half of the 125 ns link period
  localparam realtime H = 62.5;

  // Idle bus: both lines released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Data moves 15 ns after scl falls, so it never races the clock edge
  task automatic bit_c(input logic b, output logic r);
    #15 sda_low_o = ~b;
    #(H - 15) scl_o = 1'b1;
    #(H / 2) r = sda_i;
    #(H / 2) scl_o = 1'b0;
  endtask

  // Start or repeated start
  task automatic start_c;
    #15 sda_low_o = 1'b0;
    #(H - 15) scl_o = 1'b1;
    #(H / 2) sda_low_o = 1'b1;
    #(H / 2) scl_o = 1'b0;
  endtask

  task automatic stop_c;
    #15 sda_low_o = 1'b1;
    #(H - 15) scl_o = 1'b1;
    #(H / 2) sda_low_o = 1'b0;
    #(2 * H);
  endtask

  // One byte plus the acknowledge slot; sending all ones reads
  task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(tx[i], rx[i]);
    end
    bit_c(rel, r);
    ack = ~r;
  endtask

  // Word write; with full low the frame stops after the high byte
  task automatic wr_word(input logic [7:0] ptr, input logic [15:0] w, input logic full,
                         output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    a3 = 1'b1;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ptr, 1'b1, rx, a1);
    xfer(w[15:8], 1'b1, rx, a2);
    if (full) begin
      xfer(w[7:0], 1'b1, rx, a3);
    end
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Word read: pointer, repeated start, high byte acked, low byte not
  task automatic rd_word(input logic [7:0] ptr, output logic [15:0] w);
    logic a;
    logic [7:0] rx;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a);
    xfer(ptr, 1'b1, rx, a);
    start_c();
    xfer({DEV_ADDR, 1'b1}, 1'b1, rx, a);
    xfer(8'hff, 1'b0, w[15:8], a);
    xfer(8'hff, 1'b1, w[7:0], a);
    stop_c();
  endtask
endmodule

// ===== verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus row: pointer, word, readback, watched channel, its output
  typedef struct packed {
    logic [7:0] ptr;
    logic [15:0] word;
    logic [15:0] rd;
    logic [4:0] ch;
    logic [9:0] out;
  } row_t;

  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_oe;
  logic sda_lvl; // Open-drain level, must stay low
  logic strobe_n = 1'b1; // Held high except for the pulse in the load pin test
  logic [19:0][9:0] fuse_code;
  logic [19:0] fuse_used;
  logic [19:0][9:0] dac_code;
  logic lock;
  logic ok;
  logic [15:0] rd;
  int errors = 0;
  int samples_checked = 0;
  wire logic sda_line;

  // Pull-up: line is low while either party pulls it
  assign sda_line = ~(sda_oe | sda_low);

  row_t rows [8] = '{
    '{8'h00, 16'h0155, 16'h0155, 5'h00, 10'h200},
    '{8'h13, 16'h82aa, 16'h02aa, 5'h00, 10'h155},
    '{8'h04, 16'hc044, 16'h0044, 5'h04, 10'h044},
    '{8'h02, 16'h40f0, 16'h00f0, 5'h02, 10'h0f0},
    '{8'h02, 16'h400f, 16'h00ff, 5'h02, 10'h0ff},
    '{8'h14, 16'h0001, 16'h0001, 5'h02, 10'h0ff},
    '{8'h02, 16'h4300, 16'h00ff, 5'h02, 10'h0ff},
    '{8'h03, 16'h8123, 16'h0123, 5'h03, 10'h123}
  };

  always #5 mclk_i = ~mclk_i;

  otp_lock_and_dac_load dut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_lvl),
    .sda_oe_o(sda_oe),
    .output_load_strobe_n_i(strobe_n),
    .fuse_code_i(fuse_code),
    .fuse_used_i(fuse_used),
    .dac_code_o(dac_code),
    .lock_o(lock)
  );

  twowire_host host (
    .scl_o(scl),
    .sda_low_o(sda_low),
    .sda_i(sda_line)
  );

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (10) @(posedge mclk_i);
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 100 us of link traffic
  initial begin
    #400us;
    errors++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    end_of_test();
  end

  initial begin
    // Channel 1 carries a programmed fuse, the rest are blank
    fuse_code = '0;
    fuse_code[1] = 10'h0f0;
    fuse_used = '0;
    fuse_used[1] = 1'b1;
    repeat (12) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    chk_val({6'h0, dac_code[0]}, 16'h0200);
    chk_val({6'h0, dac_code[1]}, 16'h00f0);
    chk_bit(lock, 1'b0);
    $display("Test boot done");
    // Ordinary writes, OTP programming and lock, row by row
    foreach (rows[i]) begin
      host.wr_word(rows[i].ptr, rows[i].word, 1'b1, ok);
      chk_bit(ok, 1'b1);
      settle();
      chk_val({6'h0, dac_code[rows[i].ch]}, {6'h0, rows[i].out});
      host.rd_word(rows[i].ptr, rd);
      chk_val(rd, rows[i].rd);
      $display("Test row %0d done", i);
    end
    chk_bit(lock, 1'b1);
    // Pointer past the lock register is refused and loads nothing
    host.wr_word(8'h15, 16'h8111, 1'b1, ok);
    chk_bit(ok, 1'b0);
    settle();
    chk_val({6'h0, dac_code[0]}, 16'h0155);
    $display("Test bad pointer done");
    // Preload without a load event, then pulse the load pin
    host.wr_word(8'h04, 16'h0077, 1'b1, ok);
    settle();
    chk_val({6'h0, dac_code[4]}, 16'h0044);
    @(posedge mclk_i);
    #1 strobe_n = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1 strobe_n = 1'b1;
    settle();
    chk_val({6'h0, dac_code[4]}, 16'h0077);
    $display("Test load pin done");
    // A frame cut after the high byte updates nothing, not even with bit 15
    host.wr_word(8'h05, 16'h8155, 1'b0, ok);
    chk_bit(ok, 1'b1);
    settle();
    chk_val({6'h0, dac_code[4]}, 16'h0077);
    host.rd_word(8'h05, rd);
    chk_val(rd, 16'h0200);
    chk_bit(sda_lvl, 1'b0);
    $display("Test cut frame done");
    // Second reset mid-run reloads the boot image
    @(posedge mclk_i);
    #1 rst_n_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    chk_val({6'h0, dac_code[1]}, 16'h00f0);
    chk_val({6'h0, dac_code[4]}, 16'h0200);
    $display("Test second reset done");
    end_of_test();
  end
endmodule
